// *** hw/asr_alarm_status_readback.v ***
// Purpose: read-only identification and alarm status register group
//   of a dual-loop jitter attenuator, with masked alarm output
// Assumes: every status input comes from loop logic on clk_sys_i;
//   masks come from the mask registers held elsewhere in the device;
//   a lock limit under 16 makes near lock read high at any count
// Notes: reads have no side effect; data returns one cycle after
//   the read strobe; live status bytes are snapshots one cycle old,
//   the alarm follows its masked sources one cycle later, and the
//   latched record is read as it stands at the strobe
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.vh"

// Summary of operation
// - A 24-bit product code reads back low, middle, high byte at 0x78, 0x79, 0x7a.
// - Bit 0 of 0x7b returns the present level of the alarm output.
// - Bit 7 of 0x7c is high once the first loop lock counter reaches a sixteenth of its limit.
// - Bit 4 of 0x7d is high while the second loop is locked or off and outputs are unsynced.
// - Bit 3 of 0x7d is high only while both loops are locked.
// - Bit 2 of 0x7d is high while the reference pulse phase is valid and stable.
// - Bit 1 of 0x7d is high until the first sync by pin pulse or host request, then low.
// - Bit 0 of 0x7d is high once the second loop lock counter reaches a sixteenth of its limit.
// - Bit 6 of 0x7e records second loop lock acquisition until the next clear.
// - Bit 5 of 0x7e records first loop lock acquisition until the next clear.
// - Bit 4 of 0x7e records first loop holdover until the next clear.
// - Bits 3..0 of 0x7e record signal loss on each reference input until cleared.
// - Each first loop mask bit lets its matching status drive the alarm.
// - Each of system mask bits 4..0 lets its matching system status drive the alarm; bits 7..5 do nothing.
module asr_alarm_status_readback #(
  parameter CW = 16,
  parameter [23:0] PRODUCT_ID = 24'h5a3c96 // arbitrary code
) (
  input wire clk_sys_i,
  input wire rst_i,

  // register read port
  input wire rd_en_i,
  input wire [7:0] rd_addr_i,
  output wire [7:0] rd_data_o,
  output wire rd_valid_o,

  // clear of the latched event record
  input wire latch_clear_i,

  // alarm masks
  input wire [7:0] first_loop_mask_i,
  input wire [7:0] system_mask_i,

  // first loop state
  input wire first_loop_acquire_i,
  input wire first_loop_locked_i,
  input wire first_loop_holdover_i,
  input wire [CW-1:0] first_loop_lock_count_i,
  input wire [CW-1:0] first_loop_lock_limit_i,

  // second loop state
  input wire second_loop_acquire_i,
  input wire second_loop_locked_i,
  input wire second_loop_disabled_i,
  input wire [CW-1:0] second_loop_lock_count_i,
  input wire [CW-1:0] second_loop_lock_limit_i,

  // reference inputs
  input wire [3:0] reference_input_signal_loss_i,

  // synchronisation state
  input wire sysref_phase_stable_i,
  input wire ext_sync_pulse_i,
  input wire host_sync_req_i,
  input wire outputs_synced_i,

  // aggregated alarm
  output wire alarm_o
);

  // product code is arbitrary, replaced per part at integration

  // near lock: counter has reached limit / 16
  function near_lock;
    input [CW-1:0] count;
    input [CW-1:0] limit;
    begin
      near_lock = (count >= (limit >> `ASR_NEAR_SHIFT));
    end
  endfunction

  // read state machine, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ANSWER = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] rd_data_reg;
  reg [7:0] rd_data_next;

  // live status snapshots
  reg [7:0] first_status_reg;
  reg [7:0] first_status_next;
  reg [7:0] system_status_reg;
  reg [7:0] system_status_next;

  // sync history
  reg never_synced_reg;
  reg never_synced_next;

  // aggregated alarm
  reg alarm_reg;
  reg alarm_next;

  wire first_near;
  wire second_near;
  wire both_locked;
  wire sync_request;
  wire [6:0] latched_set;
  wire [6:0] latched_flags;
  wire [7:0] first_masked;
  wire [7:0] system_masked;

  // readback byte views and per-register alarm requests
  wire first_alarm;
  wire system_alarm;
  wire sync_seen;
  wire [7:0] id_low_byte;
  wire [7:0] id_mid_byte;
  wire [7:0] id_high_byte;
  wire [7:0] latched_byte;
  reg [7:0] alarm_byte;

  // near lock decode for each loop
  assign first_near = near_lock(first_loop_lock_count_i,
                                first_loop_lock_limit_i);

  // second loop near lock, same threshold rule
  assign second_near = near_lock(second_loop_lock_count_i,
                                 second_loop_lock_limit_i);

  // combined lock of both loops
  assign both_locked = first_loop_locked_i &
                       second_loop_locked_i;

  // second loop ready but outputs not yet aligned
  assign sync_request = (second_loop_locked_i | second_loop_disabled_i)
                        & ~outputs_synced_i;

  // first loop live status layout
  always @* begin
    first_status_next = `ASR_RST_BYTE;
    first_status_next[`ASR_FL_NEAR_LOCK] = first_near;
    first_status_next[`ASR_FL_ACQUIRE] = first_loop_acquire_i;
    first_status_next[`ASR_FL_LOCKED] = first_loop_locked_i;
    first_status_next[`ASR_FL_HOLDOVER] = first_loop_holdover_i;
    first_status_next[`ASR_FL_LOSS_MSB:`ASR_FL_LOSS_LSB] =
      reference_input_signal_loss_i;
  end

  // any sync event, pin pulse or host request
  assign sync_seen = ext_sync_pulse_i | host_sync_req_i;

  // sync history: cleared by the first sync of either kind
  always @* begin
    never_synced_next = never_synced_reg;
    if (sync_seen) begin
      never_synced_next = 1'b0;
    end
  end

  // system live status layout, top bits reserved as zero
  always @* begin
    system_status_next = `ASR_RST_BYTE;
    system_status_next[`ASR_SYS_SYNC_REQ] = sync_request;
    system_status_next[`ASR_SYS_BOTH_LOCKED] = both_locked;
    system_status_next[`ASR_SYS_PHASE_STABLE] =
      sysref_phase_stable_i;
    system_status_next[`ASR_SYS_NEVER_SYNCED] = never_synced_next;
    system_status_next[`ASR_SYS_SECOND_NEAR] = second_near;
  end

  // event sources of the latched record, taken as levels
  assign latched_set[`ASR_LAT_SECOND_ACQUIRE] =
    second_loop_acquire_i;
  assign latched_set[`ASR_LAT_FIRST_ACQUIRE] =
    first_loop_acquire_i;
  assign latched_set[`ASR_LAT_FIRST_HOLDOVER] =
    first_loop_holdover_i;

  // per-input signal loss sources
  assign latched_set[`ASR_LAT_LOSS_MSB:`ASR_LAT_LOSS_LSB] =
    reference_input_signal_loss_i;

  // sticky record with set-over-clear
  asr_sticky_flags #(
    .W(`ASR_LAT_WIDTH)
  ) i_asr_sticky_flags (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .set_i(latched_set),
    .clear_i(latch_clear_i),
    .flags_o(latched_flags)
  );

  // latched record byte, top bit reserved low
  assign latched_byte = {1'b0, latched_flags};

  // masked contributions to the alarm
  assign first_masked = first_loop_mask_i & first_status_next;
  assign system_masked = system_mask_i & system_status_next;

  // per-register alarm requests, reserved mask bits do nothing
  assign first_alarm = |first_masked;
  assign system_alarm = |system_masked[4:0];

  // alarm is any enabled status of either register
  always @* begin
    alarm_next = first_alarm | system_alarm;
  end

  // product code bytes, low to high
  assign id_low_byte = PRODUCT_ID[7:0];
  assign id_mid_byte = PRODUCT_ID[15:8];
  assign id_high_byte = PRODUCT_ID[23:16];

  // alarm readback byte, reserved bits low
  always @* begin
    alarm_byte = `ASR_RST_BYTE;
    alarm_byte[`ASR_ALARM_BIT] = alarm_reg;
  end

  // read mux, unmapped and reserved offsets answer zero
  always @* begin
    rd_data_next = `ASR_RST_BYTE;
    case (rd_addr_i)
      `ASR_OFS_PRODUCT_ID_LOW: begin
        rd_data_next = id_low_byte;
      end
      `ASR_OFS_PRODUCT_ID_MID: begin
        rd_data_next = id_mid_byte;
      end
      `ASR_OFS_PRODUCT_ID_HIGH: begin
        rd_data_next = id_high_byte;
      end
      `ASR_OFS_ALARM_OUTPUT: begin
        rd_data_next = alarm_byte;
      end
      `ASR_OFS_FIRST_LOOP_STATUS: begin
        rd_data_next = first_status_reg;
      end
      `ASR_OFS_SYSTEM_STATUS: begin
        rd_data_next = system_status_reg;
      end
      `ASR_OFS_LATCHED_EVENTS: begin
        rd_data_next = latched_byte;
      end
      `ASR_OFS_MISC_RESERVED: begin
        rd_data_next = `ASR_RST_BYTE;
      end
      default: begin
        rd_data_next = `ASR_RST_BYTE;
      end
    endcase
  end

  // read sequencing: one answer cycle per strobe, back to back allowed
  always @* begin
    state_next = ST_IDLE;
    case (state_reg)
      ST_IDLE: begin
        if (rd_en_i) begin
          state_next = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        if (rd_en_i) begin
          state_next = ST_ANSWER;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // read state register
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // first loop live snapshot
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      first_status_reg <= `ASR_RST_BYTE;
    end else begin
      first_status_reg <= first_status_next;
    end
  end

  // system live snapshot
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      system_status_reg <= `ASR_RST_BYTE;
    end else begin
      system_status_reg <= system_status_next;
    end
  end

  // sync history, only reset brings the flag back
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      never_synced_reg <= `ASR_RST_NEVER_SYNCED;
    end else begin
      never_synced_reg <= never_synced_next;
    end
  end

  // registered alarm level
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      alarm_reg <= `ASR_RST_ALARM;
    end else begin
      alarm_reg <= alarm_next;
    end
  end

  // read data register, only loaded on a read, no other effect
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_data_reg <= `ASR_RST_BYTE;
    end else if (rd_en_i) begin
      rd_data_reg <= rd_data_next;
    end
  end

  // answer port, data held until the next read
  assign rd_data_o = rd_data_reg;
  assign rd_valid_o = state_reg[1];

  // alarm pin level
  assign alarm_o = alarm_reg;

endmodule

`default_nettype wire

// *** hw/asr_map.vh ***
// Purpose: offsets, field positions and reset values of the alarm
//   readback register group
// Assumes: byte-wide registers on an 8-bit read address
// Notes: definitions only, no logic
`ifndef ASR_MAP_VH
`define ASR_MAP_VH

// register offsets
`define ASR_OFS_PRODUCT_ID_LOW 8'h78
`define ASR_OFS_PRODUCT_ID_MID 8'h79
`define ASR_OFS_PRODUCT_ID_HIGH 8'h7a
`define ASR_OFS_ALARM_OUTPUT 8'h7b
`define ASR_OFS_FIRST_LOOP_STATUS 8'h7c
`define ASR_OFS_SYSTEM_STATUS 8'h7d
`define ASR_OFS_LATCHED_EVENTS 8'h7e
`define ASR_OFS_MISC_RESERVED 8'h7f

// first loop status and first loop mask layout
`define ASR_FL_NEAR_LOCK 7
`define ASR_FL_ACQUIRE 6
`define ASR_FL_LOCKED 5
`define ASR_FL_HOLDOVER 4
`define ASR_FL_LOSS_MSB 3
`define ASR_FL_LOSS_LSB 0

// system status and system mask layout
`define ASR_SYS_SYNC_REQ 4
`define ASR_SYS_BOTH_LOCKED 3
`define ASR_SYS_PHASE_STABLE 2
`define ASR_SYS_NEVER_SYNCED 1
`define ASR_SYS_SECOND_NEAR 0

// latched event layout
`define ASR_LAT_SECOND_ACQUIRE 6
`define ASR_LAT_FIRST_ACQUIRE 5
`define ASR_LAT_FIRST_HOLDOVER 4
`define ASR_LAT_LOSS_MSB 3
`define ASR_LAT_LOSS_LSB 0
`define ASR_LAT_WIDTH 7

// alarm readback layout
`define ASR_ALARM_BIT 0

// reset values
`define ASR_RST_BYTE 8'h00
`define ASR_RST_LATCHED 7'h00
`define ASR_RST_NEVER_SYNCED 1'b1
`define ASR_RST_ALARM 1'b0

// near lock declared at limit divided by two to this power
`define ASR_NEAR_SHIFT 4

`endif

// *** hw/asr_sticky_flags.v ***
// Purpose: bank of sticky event flags with a common clear
// Assumes: set and clear come from logic on clk_sys_i
// Notes: a set in the clear cycle wins, so no event is lost
`timescale 1ns/1ps
`default_nettype none

module asr_sticky_flags #(
  parameter W = 7
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [W-1:0] set_i,
  input wire clear_i,
  output wire [W-1:0] flags_o
);

  reg [W-1:0] flags_reg;
  reg [W-1:0] flags_next;

  // clear drops every flag, an active set keeps or raises it
  always @* begin
    if (clear_i) begin
      flags_next = set_i;
    end else begin
      flags_next = flags_reg | set_i;
    end
  end

  // flag storage
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      flags_reg <= {W{1'b0}};
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags_o = flags_reg;

endmodule

`default_nettype wire

// *** tb/asr_alarm_status_readback_sva.sv ***
// Purpose: port checker for the alarm readback register group
// Assumes: single clock, synchronous active high reset
// Notes: bound onto the design from the bench top file
`timescale 1ns/1ps
`default_nettype none
module asr_alarm_status_readback_sva #(
  parameter CW = 16,
  parameter [23:0] PRODUCT_ID = 24'h0
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic latch_clear_i,
  input wire logic [7:0] first_loop_mask_i,
  input wire logic [7:0] system_mask_i,
  input wire logic first_loop_acquire_i,
  input wire logic first_loop_holdover_i,
  input wire logic second_loop_acquire_i,
  input wire logic [3:0] reference_input_signal_loss_i,
  input wire logic alarm_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // no pending event on any latched source
  wire quiet = !first_loop_holdover_i && !first_loop_acquire_i &&
    !second_loop_acquire_i && reference_input_signal_loss_i == 4'h0;
  // read port timing and fixed contents
  property p_rd_valid; rd_en_i |=> rd_valid_o; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("no answer");
  property p_id_low;
    rd_en_i && rd_addr_i == 8'h78 |=> rd_data_o == PRODUCT_ID[7:0];
  endproperty
  a_id_low: assert property (p_id_low) else $error("id low");
  property p_rsvd; rd_en_i && rd_addr_i == 8'h7f |=> rd_data_o == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved");
  // masked alarm sources
  property p_hold_alarm; first_loop_holdover_i && first_loop_mask_i[4]
    |=> alarm_o; endproperty
  a_hold_alarm: assert property (p_hold_alarm) else $error("holdover");
  property p_loss_alarm;
    |(reference_input_signal_loss_i & first_loop_mask_i[3:0]) |=> alarm_o;
  endproperty
  a_loss_alarm: assert property (p_loss_alarm) else $error("loss");
  property p_no_mask; first_loop_mask_i == 8'h00 && system_mask_i == 8'h00
    |=> !alarm_o; endproperty
  a_no_mask: assert property (p_no_mask) else $error("masked");
  // latched record: set by an event, emptied by a quiet clear
  sequence s_rd_latched;
    !latch_clear_i && rd_en_i && rd_addr_i == 8'h7e;
  endsequence
  sequence s_quiet_clear; latch_clear_i && quiet ##1 quiet; endsequence
  property p_sticky; first_loop_holdover_i ##1 !latch_clear_i ##1
    s_rd_latched |=> rd_data_o[4]; endproperty
  a_sticky: assert property (p_sticky) else $error("sticky");
  property p_cleared; s_quiet_clear ##1 (quiet and s_rd_latched)
    |=> rd_data_o == 8'h00; endproperty
  a_cleared: assert property (p_cleared) else $error("clear");
endmodule
`default_nettype wire

// *** tb/asr_alarm_status_readback_tb.sv ***
// Purpose: self-checking bench for the alarm readback group
// Assumes: host model issues reads and clears
// Notes: lock limits at 0x100, so near lock starts at count 0x10
`timescale 1ns/1ps
`default_nettype none
module asr_alarm_status_readback_tb;
  localparam [23:0] PID = 24'h13579b; // arbitrary code
  logic clk, rst, clr, rd_en, vld, acq1, lk1, ho1;
  logic acq2, lk2, dis2, ph, xs, hs, osy, alm;
  logic [7:0] m1, m2, addr, dat;
  logic [15:0] cnt1, cnt2, lim;
  logic [3:0] signal_loss;
  int err_total, n_tests;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  asr_alarm_status_readback #(.CW(16), .PRODUCT_ID(PID))
    i_asr_alarm_status_readback (.clk_sys_i(clk), .rst_i(rst),
    .rd_en_i(rd_en), .rd_addr_i(addr), .rd_data_o(dat), .rd_valid_o(vld),
    .latch_clear_i(clr), .first_loop_mask_i(m1), .system_mask_i(m2),
    .first_loop_acquire_i(acq1), .first_loop_locked_i(lk1),
    .first_loop_holdover_i(ho1), .first_loop_lock_count_i(cnt1),
    .first_loop_lock_limit_i(lim), .second_loop_acquire_i(acq2),
    .second_loop_locked_i(lk2), .second_loop_disabled_i(dis2),
    .second_loop_lock_count_i(cnt2), .second_loop_lock_limit_i(lim),
    .reference_input_signal_loss_i(signal_loss), .sysref_phase_stable_i(ph),
    .ext_sync_pulse_i(xs), .host_sync_req_i(hs), .outputs_synced_i(osy),
    .alarm_o(alm));
  asr_host_model i_asr_host_model (.clk_sys_i(clk), .rd_valid_i(vld),
    .rd_data_i(dat), .rd_en_o(rd_en), .rd_addr_o(addr),
    .latch_clear_o(clr));
  task print_verdict;
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // read one register and compare
  task rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    i_asr_host_model.read(a, d, ok);
    n_tests++;
    if (ok !== 1'b1 || d !== e) begin
      err_total++;
      $display("BAD reg %h exp %h got %h", a, e, d);
      if (ok !== 1'b1) print_verdict;
    end
  endtask
  task t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  // first loop status from a vector, near lock by count
  task set1(input logic [7:0] v);
    @(posedge clk);
    cnt1 <= v[7] ? 16'h0010 : 16'h000f;
    {acq1, lk1, ho1, signal_loss} <= v[6:0];
  endtask
  // one system status per vector bit, bit 1 (never synced) left undriven
  task set2(input logic [4:0] v);
    @(posedge clk);
    {dis2, lk1, lk2, osy, ph} <= {v[4], v[3], v[3], v[3], v[2]};
    cnt2 <= v[0] ? 16'h0010 : 16'h000f;
  endtask
  task t_id;
    rd(8'h78, PID[7:0]);
    rd(8'h79, PID[15:8]);
    rd(8'h7a, PID[23:16]);
    rd(8'h7f, 8'h00);
    rd(8'h00, 8'h00);
  endtask
  // never-synced flag, its mask, then a sync event
  task t_sync(input logic ext);
    @(posedge clk);
    {m1, m2} <= 16'h0002;
    rd(8'h7d, 8'h02);
    rd(8'h7b, 8'h01);
    @(posedge clk);
    m2 <= 8'h1d;
    rd(8'h7b, 8'h00);
    @(posedge clk);
    {xs, hs} <= {ext, !ext};
    @(posedge clk);
    {xs, hs} <= 2'b00;
    rd(8'h7d, 8'h00);
  endtask
  task t_first;
    for (int i = 0; i < 8; i++) begin
      set1(8'h01 << i);
      m1 <= 8'h01 << i;
      rd(8'h7c, 8'h01 << i);
      rd(8'h7b, 8'h01);
      n_tests++;
      if (alm !== 1'b1) begin
        err_total++;
        $display("BAD alarm_o exp 1 got %b", alm);
      end
      @(posedge clk);
      m1 <= ~(8'h01 << i);
      rd(8'h7b, 8'h00);
    end
  endtask
  task t_system;
    set1(8'h00);
    m1 <= 8'h00;
    for (int j = 0; j < 5; j++) begin
      if (j != 1) begin
        set2(5'h01 << j);
        m2 <= 8'h01 << j;
        rd(8'h7d, 8'h01 << j);
        rd(8'h7b, 8'h01);
        @(posedge clk);
        m2 <= ~(8'h01 << j);
        rd(8'h7b, 8'h00);
      end
    end
    // second loop locked alone: sync pending, no combined lock
    @(posedge clk);
    {dis2, lk2, osy} <= 3'b010;
    rd(8'h7d, 8'h10);
  endtask
  task t_latch;
    set2(5'h00);
    i_asr_host_model.clear;
    set1(8'h57);
    acq2 <= 1'b1;
    set1(8'h00);
    acq2 <= 1'b0;
    rd(8'h7e, 8'h77);
    rd(8'h7e, 8'h77);
    set1(8'h04);
    i_asr_host_model.clear;
    rd(8'h7e, 8'h04);
    set1(8'h00);
    i_asr_host_model.clear;
    rd(8'h7e, 8'h00);
  endtask
  initial begin
    {clk, rst, m1, m2, cnt1, cnt2} = {2'b01, 48'h0};
    {acq1, lk1, ho1, acq2, lk2, dis2, ph, xs, hs, osy, signal_loss} = '0;
    lim = 16'h0100;
    err_total = 0;
    n_tests = 0;
    t_reset;
    t_id;
    t_sync(1'b0);
    t_first;
    t_system;
    t_latch;
    t_reset;
    rd(8'h7e, 8'h00);
    t_sync(1'b1);
    print_verdict;
  end
endmodule
bind asr_alarm_status_readback asr_alarm_status_readback_sva #(.CW(CW),
  .PRODUCT_ID(PRODUCT_ID)) i_asr_alarm_status_readback_sva (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rd_en_i(rd_en_i),
  .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .latch_clear_i(latch_clear_i), .first_loop_mask_i(first_loop_mask_i),
  .system_mask_i(system_mask_i),
  .first_loop_acquire_i(first_loop_acquire_i),
  .first_loop_holdover_i(first_loop_holdover_i),
  .second_loop_acquire_i(second_loop_acquire_i),
  .reference_input_signal_loss_i(reference_input_signal_loss_i),
  .alarm_o(alarm_o));
`default_nettype wire

// *** tb/asr_host_model.sv ***
// Purpose: serial control host stand-in issuing reads and clears
// Assumes: one read at a time on the read strobe
// Notes: address is scrambled once the strobe drops
`timescale 1ns/1ps
`default_nettype none
module asr_host_model (
  input wire logic clk_sys_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output var logic rd_en_o,
  output var logic [7:0] rd_addr_o,
  output var logic latch_clear_o
);
  // idle at time zero
  initial begin
    rd_en_o = 1'b0;
    rd_addr_o = 8'h00;
    latch_clear_o = 1'b0;
  end
  // one read, answer awaited a few cycles
  task automatic read(input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    @(posedge clk_sys_i);
    rd_en_o <= 1'b1;
    rd_addr_o <= a;
    @(posedge clk_sys_i);
    rd_en_o <= 1'b0;
    rd_addr_o <= ~a; // no stale address
    ok = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 4 && !ok; n++) begin
      #1;
      if (rd_valid_i === 1'b1) begin
        ok = 1'b1;
        d = rd_data_i;
      end else
        @(posedge clk_sys_i);
    end
  endtask
  // one-cycle clear strobe
  task automatic clear;
    @(posedge clk_sys_i);
    latch_clear_o <= 1'b1;
    @(posedge clk_sys_i);
    latch_clear_o <= 1'b0;
  endtask
endmodule
`default_nettype wire
